/* core/fgsc_ctrl.v */
`timescale 1ns/100ps
`default_nettype none
`include "fgsc_defs.vh"

// Function
// R1: Host lowers frame select before any transfer; high select starts nothing.
// R2: First rising clock after select falls samples direction: one write, zero read.
// R3: Write captures eight data bits on following rising edges, LSB first.
// R4: Select rising after a write applies the shifted word to filters and amps.
// R5: Read drives stored word on read output, one bit per falling edge, LSB first.
// R6: Read ends when select rises; stored word is never changed by a read.
// R7: One 8-bit word: 5-bit corner code plus preamp, postamp, VGA gain bits.
// R8: The single word sets both channels together; no per-channel settings.
// R9: Offset loop disable high turns the dc offset loop off; low runs it.
// R10: Corner in B8..B4, preamp B3, postamp B2, VGA max gain B1.
// R11: Corner code n gives n MHz; code zero passes no signal.
// R12: With select high, clock and data are ignored and the word is held.
module fgsc_ctrl (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Serial port pins
  input wire frame_select_n,
  input wire serial_clk,
  input wire serial_data_in,
  output reg serial_read_out,
  output reg serial_read_oe_n,
  // Applied settings, shared by both channels
  output reg [4:0] corner_code,
  output reg corner_enable,
  output reg preamp_gain_hi,
  output reg postamp_gain_hi,
  output reg vga_max_gain_hi,
  output reg offset_loop_disable,
  output reg offset_loop_on
);

  // ****************************************
  // Pin synchronisation
  // ****************************************
  // Pins are async to pclk, so each passes two flops
  // Link edges are therefore seen about three pclk late
  // Host must hold each level for at least three pclk
  // Data must lead the clock rise by the same margin
  wire [2:0] pins_s;
  wire sel_n_s;
  wire sck_s;
  wire sdi_s;

  fgsc_sync #(
    .WIDTH(3),
    .RST_VAL(3'h4)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({frame_select_n, serial_clk, serial_data_in}),
    .sync_out(pins_s)
  );

  assign sel_n_s = pins_s[2];
  assign sck_s = pins_s[1];
  assign sdi_s = pins_s[0];

  // ****************************************
  // Edge detection on synced pins
  // ****************************************
  reg sel_n_q;
  reg sck_q;
  wire sck_rise;
  wire sck_fall;
  wire sel_fall;
  wire sel_rise;

  // Reset values match the idle pin levels: no false edge
  // Select edges are seen through the same two flops
  // Previous values of synced select and clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_n_q <= 1'b1;
      sck_q <= 1'b0;
    end else begin
      sel_n_q <= sel_n_s;
      sck_q <= sck_s;
    end
  end

  // Link edges only count while select is low
  assign sck_rise = sck_s & ~sck_q & ~sel_n_s; // R12
  assign sck_fall = ~sck_s & sck_q & ~sel_n_s; // R12
  assign sel_fall = ~sel_n_s & sel_n_q; // R1
  assign sel_rise = sel_n_s & ~sel_n_q;

  // ****************************************
  // Frame state machine
  // ****************************************
  // IDLE waits for select to fall
  // DIR takes the direction bit on the first clock rise
  // WRITE shifts in eight bits, first bit lands in bit 0
  // READ shifts a snapshot out on falling clock edges
  // A select rise ends the frame in any state
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_DIR = 2'b01;
  localparam [1:0] ST_WRITE = 2'b10;
  localparam [1:0] ST_READ = 2'b11;

  // Serial frame state
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`FGSC_CNT_W-1:0] cnt_q;
  reg [`FGSC_CNT_W-1:0] cnt_d;
  reg [`FGSC_WORD_W-1:0] shift_q;
  reg [`FGSC_WORD_W-1:0] shift_d;
  reg [`FGSC_WORD_W-1:0] word_q;
  reg [`FGSC_WORD_W-1:0] word_d;
  reg [`FGSC_WORD_W-1:0] rd_q;
  reg [`FGSC_WORD_W-1:0] rd_d;
  // Read output next values
  reg sdo_d;
  reg oe_n_d;
  // Completed frame counter, wraps at 16 bits
  reg [15:0] frames_q;
  reg frame_done;

  // Next-state logic of the serial frame
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    word_d = word_q;
    rd_d = rd_q;
    sdo_d = serial_read_out;
    oe_n_d = serial_read_oe_n;
    frame_done = 1'b0;
    case (state_q)
      ST_IDLE: begin
        oe_n_d = 1'b1; // R12
        if (sel_fall) begin // R1
          state_d = ST_DIR;
          cnt_d = `FGSC_CNT_ZERO;
        end
      end
      ST_DIR: begin
        if (sel_n_s) begin
          state_d = ST_IDLE;
        end else if (sck_rise) begin
          cnt_d = `FGSC_CNT_ONE;
          if (sdi_s) begin // R2
            state_d = ST_WRITE;
          end else begin
            state_d = ST_READ;
            // Snapshot keeps the stored word out of the shift path
            rd_d = word_q; // R6
          end
        end
      end
      ST_WRITE: begin
        if (sel_n_s) begin
          state_d = ST_IDLE;
          frame_done = 1'b1;
          // Fewer than eight bits leaves the word untouched
          if (cnt_q == `FGSC_CNT_DATA_END) begin
            word_d = shift_q; // R4
          end
        end else if (sck_rise && cnt_q != `FGSC_CNT_DATA_END) begin
          // Stops at the eighth bit; later clocks are ignored
          shift_d = {sdi_s, shift_q[`FGSC_WORD_W-1:1]}; // R3
          cnt_d = cnt_q + `FGSC_CNT_ONE;
        end
      end
      ST_READ: begin
        if (sel_n_s) begin
          state_d = ST_IDLE; // R6
          oe_n_d = 1'b1;
          frame_done = 1'b1;
        end else if (sck_fall && cnt_q != `FGSC_CNT_DATA_END) begin
          // Enable drops with the first bit, rises with select
          sdo_d = rd_q[0]; // R5
          oe_n_d = 1'b0;
          rd_d = {1'b0, rd_q[`FGSC_WORD_W-1:1]};
          cnt_d = cnt_q + `FGSC_CNT_ONE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Read output and its enable come straight from flops
  // Frame registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cnt_q <= `FGSC_CNT_ZERO;
      shift_q <= `FGSC_WORD_RST;
      word_q <= `FGSC_WORD_RST;
      rd_q <= `FGSC_WORD_RST;
      serial_read_out <= 1'b0;
      serial_read_oe_n <= 1'b1;
      frames_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      word_q <= word_d;
      rd_q <= rd_d;
      serial_read_out <= sdo_d;
      serial_read_oe_n <= oe_n_d;
      // Counter bumps once per completed frame
      if (frame_done) begin
        frames_q <= frames_q + 16'h0001;
      end
    end
  end

  // ****************************************
  // APB registers
  // ****************************************
  reg ofdis_q;
  wire apb_setup;
  wire apb_wr;
  wire addr_ok;
  wire [31:0] status_word;

  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pready & pwrite;
  assign addr_ok = (paddr == `FGSC_ADDR_CTRL) || (paddr == `FGSC_ADDR_STATUS) ||
                   (paddr == `FGSC_ADDR_WORD) || (paddr == `FGSC_ADDR_COUNT);

  // Status: select active, frame state, synced select, driving
  assign status_word = {27'h0, ~sel_n_s, state_q, sel_n_s, ~serial_read_oe_n};

  // One wait-free access: pready rises in the access cycle
  // The setup edge registers the answer, so no wait state is needed
  // pready and pslverr then stand for the access cycle only
  // prdata holds until the next setup
  // Unmapped offsets answer with pslverr and zero data
  // Writes to read-only offsets are dropped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      ofdis_q <= `FGSC_CTRL_RST;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~addr_ok;
      if (apb_wr && paddr == `FGSC_ADDR_CTRL) begin
        ofdis_q <= pwdata[`FGSC_CTRL_OFDIS];
      end
      if (apb_setup && !pwrite) begin
        case (paddr)
          `FGSC_ADDR_CTRL: prdata <= {31'h0, ofdis_q};
          `FGSC_ADDR_STATUS: prdata <= status_word;
          `FGSC_ADDR_WORD: prdata <= {24'h0, word_q};
          `FGSC_ADDR_COUNT: prdata <= {16'h0, frames_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end else if (apb_setup) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // Applied analog settings
  // ****************************************
  // One word drives both channels
  // Corner and gain outputs follow the word register one pclk later
  // Code zero mutes the filter path
  // Gain bits pass through unchanged
  // Offset loop control comes from the APB bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      corner_code <= 5'h00;
      corner_enable <= 1'b0;
      preamp_gain_hi <= 1'b0;
      postamp_gain_hi <= 1'b0;
      vga_max_gain_hi <= 1'b0;
      offset_loop_disable <= 1'b0;
      offset_loop_on <= 1'b1;
    end else begin
      corner_code <= word_q[`FGSC_CORNER_HI:`FGSC_CORNER_LO]; // R7 R8 R10
      corner_enable <= word_q[`FGSC_CORNER_HI:`FGSC_CORNER_LO] != `FGSC_CORNER_OFF; // R11
      preamp_gain_hi <= word_q[`FGSC_PRE_BIT]; // R10
      postamp_gain_hi <= word_q[`FGSC_POST_BIT]; // R10
      vga_max_gain_hi <= word_q[`FGSC_VGA_BIT]; // R10
      offset_loop_disable <= ofdis_q; // R9
      offset_loop_on <= ~ofdis_q; // R9
    end
  end

endmodule

`default_nettype wire

/* core/fgsc_defs.vh */
`ifndef FGSC_DEFS_VH
`define FGSC_DEFS_VH

// ****************************************
// APB register map (byte addresses)
// ****************************************
`define FGSC_ADDR_CTRL 8'h00
`define FGSC_ADDR_STATUS 8'h04
`define FGSC_ADDR_WORD 8'h08
`define FGSC_ADDR_COUNT 8'h0C

// ****************************************
// Control register fields
// ****************************************
`define FGSC_CTRL_OFDIS 0
`define FGSC_CTRL_RST 1'b0

// ****************************************
// Control word layout
// ****************************************
`define FGSC_WORD_W 8
`define FGSC_CORNER_HI 7
`define FGSC_CORNER_LO 3
`define FGSC_PRE_BIT 2
`define FGSC_POST_BIT 1
`define FGSC_VGA_BIT 0
`define FGSC_WORD_RST 8'h00
`define FGSC_CORNER_OFF 5'h00

// ****************************************
// Serial sequencing
// ****************************************
`define FGSC_CNT_W 4
`define FGSC_CNT_DATA_END 4'h9
`define FGSC_CNT_ZERO 4'h0
`define FGSC_CNT_ONE 4'h1

`endif

/* core/fgsc_sync.v */
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Two-stage synchroniser, one per bit
// ****************************************
module fgsc_sync #(
  parameter WIDTH = 3,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Async in, synced out
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      // First stage feeds only the second
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q <= RST_VAL[i];
          sync_q <= RST_VAL[i];
        end else begin
          meta_q <= async_in[i];
          sync_q <= meta_q;
        end
      end
      assign sync_out[i] = sync_q;
    end
  endgenerate

endmodule

`default_nettype wire

/* dv/fgsc_ctrl_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
// ******
// Port checker
// ******
module fgsc_ctrl_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus and pins
  input wire logic pready,
  input wire logic frame_select_n,
  input wire logic serial_read_oe_n,
  // Applied settings
  input wire logic [4:0] corner_code,
  input wire logic corner_enable,
  input wire logic preamp_gain_hi,
  input wire logic postamp_gain_hi,
  input wire logic vga_max_gain_hi,
  input wire logic offset_loop_disable,
  input wire logic offset_loop_on
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Select held high long enough for any apply to land
  sequence s_idle;
    frame_select_n [*8] ##1 frame_select_n [*4];
  endsequence
  property p_loop_inv;
    offset_loop_on == !offset_loop_disable;
  endproperty
  a_loop_inv: assert property (p_loop_inv)
    else $error("loop enable not inverse of disable");
  property p_corner_en;
    corner_enable == (corner_code != 5'h00);
  endproperty
  a_corner_en: assert property (p_corner_en)
    else $error("corner enable wrong for code");
  property p_oe_idle;
    s_idle |-> serial_read_oe_n;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("read output driven while deselected");
  property p_hold;
    s_idle |=> $stable({corner_code, preamp_gain_hi, postamp_gain_hi, vga_max_gain_hi});
  endproperty
  a_hold: assert property (p_hold)
    else $error("settings moved while deselected");
  property p_apply;
    !frame_select_n [*4] |=> $stable(corner_code);
  endproperty
  a_apply: assert property (p_apply)
    else $error("corner changed inside a frame");
  property p_oe_fell;
    $fell(serial_read_oe_n) |-> !frame_select_n;
  endproperty
  a_oe_fell: assert property (p_oe_fell)
    else $error("read output enabled outside a frame");
  property p_oe_rel;
    $rose(frame_select_n) |-> ##[1:8] serial_read_oe_n;
  endproperty
  a_oe_rel: assert property (p_oe_rel)
    else $error("read output not released after frame");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
endmodule
`default_nettype wire

/* dv/fgsc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ******
// Host side of the serial port
// ******
module fgsc_host_model #(
  parameter int HALF = 4
) (
  // Clock
  input wire logic pclk,
  // Serial pins
  output var logic frame_select_n,
  output var logic serial_clk,
  output var logic serial_data_in,
  input wire logic serial_read_out
);
  // Idle: deselected, clock parked low
  initial begin
    frame_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
  end
  // Wait whole pclk cycles
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Data set up, then a rising serial clock
  task automatic pulse(input logic d);
    serial_data_in <= d;
    wt(HALF);
    serial_clk <= 1'b1;
    wt(HALF);
  endtask
  // One frame: direction bit, then n bits LSB first
  task automatic xfer(input logic dir, input logic [7:0] w, input int n,
      output logic [7:0] r);
    r = 8'h00;
    frame_select_n <= 1'b0;
    wt(HALF);
    pulse(dir);
    serial_clk <= 1'b0;
    for (int i = 0; i < n; i++) begin
      pulse(w[i]);
      r[i] = serial_read_out;
      serial_clk <= 1'b0;
    end
    wt(HALF);
    frame_select_n <= 1'b1;
    serial_data_in <= ~serial_data_in;
    wt(2 * HALF);
  endtask
  // Clock and data toggling while deselected
  task automatic noise();
    for (int i = 0; i < 4; i++) begin
      pulse(~serial_data_in);
      serial_clk <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* dv/filter_gain_serial_ctrl_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fgsc_defs.vh"
module filter_gain_serial_ctrl_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  wire [31:0] prdata;
  wire pready, pslverr, frame_select_n, serial_clk, serial_data_in;
  wire serial_read_out, serial_read_oe_n, corner_enable, offset_loop_disable;
  wire [4:0] corner_code;
  wire preamp_gain_hi, postamp_gain_hi, vga_max_gain_hi, offset_loop_on;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic er;
  logic [7:0] sr;
  // Clock
  always #20 pclk = ~pclk;
  fgsc_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .frame_select_n, .serial_clk, .serial_data_in,
    .serial_read_out, .serial_read_oe_n, .corner_code, .corner_enable,
    .preamp_gain_hi, .postamp_gain_hi, .vga_max_gain_hi, .offset_loop_disable,
    .offset_loop_on);
  fgsc_host_model host (.pclk, .frame_select_n, .serial_clk, .serial_data_in,
    .serial_read_out);
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; read data and error left in rd and er
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic final_report();
    $display("mismatches %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(32'(serial_read_oe_n), 32'h1);
    apb(1'b0, `FGSC_ADDR_STATUS, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, `FGSC_ADDR_WORD, 32'h0);
    chk(rd, 32'h0);
    host.xfer(1'b1, 8'hA5, 8, sr);
    chk(32'(corner_code), 32'h14);
    chk(32'({preamp_gain_hi, postamp_gain_hi, vga_max_gain_hi}), 32'h5);
    apb(1'b0, `FGSC_ADDR_WORD, 32'h0);
    chk(rd, 32'hA5);
    host.xfer(1'b0, 8'hFF, 8, sr);
    chk(32'(sr), 32'hA5);
    chk(32'(serial_read_oe_n), 32'h1);
    host.xfer(1'b1, 8'h00, 5, sr);
    host.noise();
    apb(1'b0, `FGSC_ADDR_WORD, 32'h0);
    chk(rd, 32'hA5);
    for (int n = 0; n < 32; n++) begin
      host.xfer(1'b1, {n[4:0], 3'b010}, 8, sr);
      chk(32'(corner_code), n);
      chk(32'(corner_enable), 32'(n != 0));
    end
    chk(32'({preamp_gain_hi, postamp_gain_hi, vga_max_gain_hi}), 32'h2);
    apb(1'b1, `FGSC_ADDR_CTRL, 32'h1);
    apb(1'b0, `FGSC_ADDR_CTRL, 32'h0);
    chk(rd, 32'h1);
    chk(32'({offset_loop_disable, offset_loop_on}), 32'h2);
    apb(1'b1, `FGSC_ADDR_CTRL, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'({er, offset_loop_on}), 32'h3);
    chk(rd, 32'h0);
    apb(1'b1, `FGSC_ADDR_WORD, 32'h0);
    apb(1'b0, `FGSC_ADDR_WORD, 32'h0);
    chk(rd, 32'hFA);
    apb(1'b0, `FGSC_ADDR_COUNT, 32'h0);
    chk(rd, 32'h23);
    final_report();
  end
endmodule
bind fgsc_ctrl fgsc_ctrl_asserts u_chk (.pclk, .presetn, .pready, .frame_select_n,
  .serial_read_oe_n, .corner_code, .corner_enable, .preamp_gain_hi,
  .postamp_gain_hi, .vga_max_gain_hi, .offset_loop_disable, .offset_loop_on);
`default_nettype wire
